// File: tb/plss_line_sync_shaper_asserts.sv
// checker for the line-sync shaper, mirrors the two control registers
// assumes it is bound to the top and sees only the top's ports
module plss_line_sync_shaper_asserts #(
  parameter int PIX_W = 18
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // timing, pixels and panel pins
  input wire logic incoming_line_sync,
  input wire logic incoming_frame_sync,
  input wire logic [PIX_W-1:0] incoming_pixel_data,
  input wire logic panel_line_pulse,
  input wire logic frame_start_marker,
  input wire logic [PIX_W-1:0] panel_pixel_data
);
  logic [31:0] a_r, a_nxt, b_r, b_nxt, rd_exp;
  logic [5:0] cnt_r, cnt_nxt, lead, trail;
  logic [2:0] quiet_r, quiet_nxt;
  logic n_r, armed_r, armed_nxt, n, e, inv, byp, regen;
  assign n = incoming_line_sync ^ a_r[29];
  assign e = n && !n_r;
  assign inv = b_r[26] && b_r[22];
  assign byp = b_r[30];
  assign regen = a_r[27] && !byp;
  assign lead = (a_r[7:5] == 3'h0) ? 6'h00 : {3'h0, a_r[7:5]} + 6'h01;
  assign trail = {1'b0, a_r[4:0]};
  assign rd_exp = (reg_addr == plss_pkg::OFS_CTRL_A) ? a_r :
                  (reg_addr == plss_pkg::OFS_CTRL_B) ? b_r : 32'h0000_0000;
  // a write voids the timing history, so checks wait for fresh lines
  always_comb begin
    a_nxt = a_r;
    b_nxt = b_r;
    quiet_nxt = quiet_r + {2'h0, ~&quiet_r};
    armed_nxt = armed_r || e;
    cnt_nxt = e ? 6'h01 : cnt_r + {5'h00, ~&cnt_r};
    if (reg_wr) begin
      quiet_nxt = 3'h0;
      armed_nxt = 1'b0;
      if (reg_addr == plss_pkg::OFS_CTRL_A) begin
        a_nxt = reg_wdata & 32'h2FFF_00FF;
      end
      if (reg_addr == plss_pkg::OFS_CTRL_B) begin
        b_nxt = reg_wdata & 32'h45FC_0000;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_r <= 32'h0000_0000;
      b_r <= 32'h0000_0000;
      quiet_r <= 3'h0;
      armed_r <= 1'b0;
      cnt_r <= 6'h00;
      n_r <= 1'b0;
    end else begin
      a_r <= a_nxt;
      b_r <= b_nxt;
      quiet_r <= quiet_nxt;
      armed_r <= armed_nxt;
      cnt_r <= cnt_nxt;
      n_r <= n;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_regen_edge;
    e && regen && lead == 6'h00 && trail > 6'h01 && quiet_r > 3'h2;
  endsequence
  sequence s_lead_zero;
    ##1 (panel_line_pulse == inv) ##1 (panel_line_pulse != inv);
  endsequence
  chk_reset_quiet: assert property ($rose(rst_n) |-> reg_rdata == 32'h0000_0000
    && !panel_line_pulse && !frame_start_marker)
    else $error("outputs not idle after reset");
  chk_reg_read: assert property ($past(reg_rd) && $past(reg_addr) !=
    plss_pkg::OFS_STATUS |-> reg_rdata == $past(rd_exp))
    else $error("register read data wrong");
  chk_rd_window: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  chk_edge_anchor: assert property (s_regen_edge |-> s_lead_zero)
    else $error("line pulse not anchored to sync edge");
  chk_regen_shape: assert property (armed_r && regen && cnt_r != 6'h00 |->
    panel_line_pulse == (inv ^ (cnt_r >= lead + 6'h02 &&
    cnt_r <= trail + 6'h01 && trail > lead)))
    else $error("shaped line pulse misplaced");
  chk_no_pulse: assert property (armed_r && regen && trail <= lead |->
    panel_line_pulse == inv)
    else $error("pulse with empty length");
  chk_plain_sync: assert property (quiet_r > 3'h2 && !regen && !byp |->
    panel_line_pulse == ($past(n, 2) ^ inv))
    else $error("unshaped sync path wrong");
  chk_bypass_path: assert property (quiet_r > 3'h1 && byp |->
    panel_line_pulse == $past(incoming_line_sync) &&
    frame_start_marker == $past(incoming_frame_sync) &&
    panel_pixel_data == $past(incoming_pixel_data))
    else $error("bypass path wrong");
  chk_tft_marker: assert property (quiet_r > 3'h2 && !byp &&
    b_r[21:18] > 4'h2 |-> frame_start_marker ==
    ($past(incoming_frame_sync, 2) ^ (b_r[24] && b_r[23])))
    else $error("panel marker wrong");
endmodule : plss_line_sync_shaper_asserts

bind plss_line_sync_shaper plss_line_sync_shaper_asserts #(
  .PIX_W(PIX_W)
) i_plss_line_sync_shaper_asserts (
  .clock(clock),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .incoming_line_sync(incoming_line_sync),
  .incoming_frame_sync(incoming_frame_sync),
  .incoming_pixel_data(incoming_pixel_data),
  .panel_line_pulse(panel_line_pulse),
  .frame_start_marker(frame_start_marker),
  .panel_pixel_data(panel_pixel_data)
);

// File: tb/plss_line_sync_shaper_tb_top.sv
// bench for the line-sync shaper: register tasks and line measurements
// assumes the upstream model drives all timing and pixel inputs
module plss_line_sync_shaper_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic up_low = 1'b0;
  logic inv_x = 1'b0;
  logic [31:0] reg_rdata, got;
  logic line_in, frame_in, pulse, marker, mark10;
  logic [17:0] raw_pix, proc_pix, pix_out;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int first, cnt, ld;
  int tr[3] = '{0, 1, 31};
  logic [31:0] pb[2] = '{32'h0440_0000, 32'h0040_0000};
  logic [3:0] pt[3] = '{4'h3, 4'h2, 4'h0};
  logic [3:0] mk[3] = '{4'b0000, 4'b0001, 4'b0101};
  plss_line_sync_shaper i_plss_line_sync_shaper (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .incoming_line_sync(line_in),
    .incoming_frame_sync(frame_in), .incoming_pixel_data(raw_pix),
    .internal_pixel_data(proc_pix), .panel_line_pulse(pulse),
    .frame_start_marker(marker), .panel_pixel_data(pix_out));
  plss_upstream_model i_plss_upstream_model (
    .clock(clock), .active_low(up_low), .line_sync(line_in),
    .frame_sync(frame_in), .raw_pix(raw_pix), .proc_pix(proc_pix));
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask : rd
  // settle lets any pulse from a polarity change die out
  task automatic cfg(input logic [31:0] a, input logic [31:0] b);
    wr(plss_pkg::OFS_CTRL_A, a);
    wr(plss_pkg::OFS_CTRL_B, b);
    up_low <= a[29];
    repeat (40) @(posedge clock);
  endtask : cfg
  // k counts edges from the one that raises the input sync
  task automatic line(input int w);
    first = 0;
    cnt = 0;
    @(posedge clock);
    #1 i_plss_upstream_model.start_line(w);
    for (int k = 0; k < 40; k++) begin
      @(posedge clock);
      #1;
      if (k == 10) mark10 = marker;
      if (pulse ^ inv_x) begin
        cnt++;
        if (first == 0) first = k;
      end
    end
  endtask : line
  task automatic print_verdict();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(plss_pkg::OFS_CTRL_A);
    check(got, plss_pkg::CTRL_A_RESET);
    line(3);
    check(first, 2);
    check(cnt, 3);
    wr(plss_pkg::OFS_CTRL_A, 32'hFFFF_FFFF);
    rd(plss_pkg::OFS_CTRL_A);
    check(got, 32'h2FFF_00FF);
    wr(12'h40C, 32'hFFFF_FFFF);
    rd(12'h40C);
    check(got, 32'h0000_0000);
    for (int c = 0; c < 8; c++) begin
      cfg(32'h0800_000C | (c << 5), 32'h0000_0000);
      line(3);
      ld = (c == 0) ? 0 : c + 1;
      check(first, 2 + ld);
      check(cnt, 12 - ld);
    end
    foreach (tr[i]) begin
      cfg(32'h0800_0000 | tr[i], 32'h0000_0000);
      line(3);
      check(cnt, tr[i]);
      check(first, (tr[i] == 0) ? 0 : 2);
    end
    cfg(32'h0800_00E8, 32'h0000_0000);
    line(3);
    check(cnt, 0);
    cfg(32'h0000_0034, 32'h0000_0000);
    line(3);
    check(cnt, 3);
    cfg(32'h2000_0000, 32'h0000_0000);
    line(5);
    check(cnt, 5);
    cfg(32'h2800_0034, 32'h0000_0000);
    line(3);
    check(first, 4);
    check(cnt, 18);
    foreach (pb[i]) begin
      cfg(32'h0800_0034, pb[i]);
      inv_x = pb[i][26];
      line(3);
      check(first, 4);
      check(cnt, 18);
    end
    inv_x = 1'b0;
    cfg(32'h0800_0034, 32'h4000_0000);
    line(3);
    check(first, 1);
    check(cnt, 3);
    for (int p = 0; p < 3; p++) begin
      cfg(32'h0004_0000, {10'h000, pt[p], 18'h0_0000});
      #1 i_plss_upstream_model.start_frame(2);
      repeat (4) @(posedge clock);
      for (int l = 0; l < 4; l++) begin
        line(3);
        check(mark10, mk[p][l]);
      end
    end
    rd(plss_pkg::OFS_STATUS);
    check(got[10:0], 11'h004);
    // tft type with marker inversion: idle marker reads high
    cfg(32'h0004_0000, 32'h018C_0000);
    #1 check(marker, 1'b1);
    // normal mode shows the processed stream one clock late
    check(pix_out, 18'(proc_pix + 18'h0_0001));
    print_verdict();
  end
endmodule : plss_line_sync_shaper_tb_top

// File: tb/plss_upstream_model.sv
// upstream companion model: line and frame syncs plus pixel streams
// assumes pulses are requested between clock edges
module plss_upstream_model (
  // clock and setup
  input wire logic clock,
  input wire logic active_low,
  // timing and pixels
  output logic line_sync,
  output logic frame_sync,
  output logic [17:0] raw_pix,
  output logic [17:0] proc_pix
);
  timeunit 1ns;
  timeprecision 1ps;
  int line_left = 0;
  int frame_left = 0;
  logic line_on = 1'b0;
  task automatic start_line(input int w);
    line_left = w;
  endtask : start_line
  task automatic start_frame(input int w);
    frame_left = w;
  endtask : start_frame
  // idle level is the inactive one of the chosen polarity
  assign line_sync = line_on ^ active_low;
  assign proc_pix = ~raw_pix;
  initial begin
    frame_sync = 1'b0;
    raw_pix = 18'h0_0000;
  end
  // pixels change every cycle so a stale path cannot pass
  always @(posedge clock) begin
    line_on <= (line_left > 0);
    frame_sync <= (frame_left > 0);
    raw_pix <= raw_pix + 18'h0_0001;
    if (line_left > 0) line_left <= line_left - 1;
    if (frame_left > 0) frame_left <= frame_left - 1;
  end
endmodule : plss_upstream_model

// File: verilog/plss_edge_pulse.sv
// edge-delay pulse generator: counts pixel clocks from a start strobe
// assumes start is a one-cycle pulse on the asserting input edge
module plss_edge_pulse #(
  parameter int CNT_W = 5
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // timing
  input wire logic start,
  input wire logic [CNT_W-1:0] lead,
  input wire logic [CNT_W-1:0] trail,
  // result
  output logic pulse_r
);
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;
  logic pulse_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (start) begin
      cnt_nxt = '0;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r == {CNT_W{1'b1}}) begin
        run_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
    // empty or inverted window yields no pulse at all
    pulse_nxt = run_nxt && (cnt_nxt >= lead) && (cnt_nxt < trail);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      pulse_r <= pulse_nxt;
    end
  end
endmodule : plss_edge_pulse

// File: verilog/plss_frame_marker.sv
// frame start marker: per-frame line counting for STN panels
// assumes line_edge and frame_edge are one-cycle strobes
module plss_frame_marker #(
  parameter int LINE_W = 11
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // events and mode
  input wire logic line_edge,
  input wire logic frame_edge,
  input wire logic frame_level,
  input wire logic dual_scan,
  input wire logic single_scan,
  input wire logic [LINE_W-1:0] line_count,
  // result
  output logic marker_r,
  output logic [LINE_W-1:0] line_idx_r
);
  plss_pkg::plss_frame_st_t st_r, st_nxt;
  logic marker_nxt;
  logic [LINE_W-1:0] line_idx_nxt;
  logic [LINE_W-1:0] half;

  always_comb begin
    half = line_count >> 1;
    st_nxt = st_r;
    marker_nxt = marker_r;
    line_idx_nxt = line_idx_r;
    if (!(dual_scan || single_scan)) begin
      // line count has no effect outside STN modes
      st_nxt = plss_pkg::PLSS_WAIT_FRAME;
      marker_nxt = frame_level;
      line_idx_nxt = '0;
    end else if (frame_edge) begin
      st_nxt = plss_pkg::PLSS_FIRST_LINE;
      marker_nxt = 1'b0;
      line_idx_nxt = '0;
    end else if (line_edge) begin
      marker_nxt = 1'b0;
      case (st_r)
        plss_pkg::PLSS_FIRST_LINE: begin
          marker_nxt = 1'b1;
          line_idx_nxt = {{(LINE_W-1){1'b0}}, 1'b1};
          st_nxt = plss_pkg::PLSS_COUNT;
        end
        plss_pkg::PLSS_COUNT: begin
          marker_nxt = dual_scan && (half != '0) && (line_idx_r == half);
          line_idx_nxt = line_idx_r + 1'b1;
          if (line_idx_nxt >= line_count) begin
            st_nxt = plss_pkg::PLSS_WAIT_FRAME;
          end
        end
        plss_pkg::PLSS_WAIT_FRAME: begin
          st_nxt = plss_pkg::PLSS_WAIT_FRAME;
        end
        default: begin
          st_nxt = plss_pkg::PLSS_WAIT_FRAME;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= plss_pkg::PLSS_WAIT_FRAME;
      marker_r <= 1'b0;
      line_idx_r <= '0;
    end else begin
      st_r <= st_nxt;
      marker_r <= marker_nxt;
      line_idx_r <= line_idx_nxt;
    end
  end
endmodule : plss_frame_marker

// File: verilog/plss_line_sync_shaper.sv
// panel line-sync shaper top: registers, sync normalising, pulse regen,
// frame marker and bypass muxing onto the panel pins
// assumes all inputs are synchronous to the pixel clock
//
// The address-and-strobe port is this design's own decision.
module plss_line_sync_shaper #(
  parameter int PIX_W = 18
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // upstream timing and pixels
  input wire logic incoming_line_sync,
  input wire logic incoming_frame_sync,
  input wire logic [PIX_W-1:0] incoming_pixel_data,
  input wire logic [PIX_W-1:0] internal_pixel_data,
  // panel pins
  output logic panel_line_pulse,
  output logic frame_start_marker,
  output logic [PIX_W-1:0] panel_pixel_data
);
  localparam int LW = plss_pkg::A_LINES_W;

  // register A state
  logic in_pol_r, in_pol_nxt;
  logic regen_r, regen_nxt;
  logic [LW-1:0] lines_r, lines_nxt;
  logic [2:0] lead_code_r, lead_code_nxt;
  logic [4:0] trail_code_r, trail_code_nxt;
  // register B state
  logic bypass_r, bypass_nxt;
  logic hs_out_sel_r, hs_out_sel_nxt;
  logic vs_pol_en_r, vs_pol_en_nxt;
  logic vs_pol_r, vs_pol_nxt;
  logic hs_pol_r, hs_pol_nxt;
  logic [3:0] ptype_r, ptype_nxt;
  // read port
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] ctrl_a_view, ctrl_b_view, status_view;
  // sync path
  logic line_norm, line_prev_r, line_edge;
  logic frame_norm, frame_prev_r, frame_edge;
  logic line_pass_r, line_pass_nxt;
  logic [4:0] lead_cyc, trail_cyc;
  logic shaped_pulse;
  logic marker;
  logic [LW-1:0] line_idx;
  logic dual_scan, single_scan;
  // output flops
  logic line_out_r, line_out_nxt;
  logic mark_out_r, mark_out_nxt;
  logic [PIX_W-1:0] pix_out_r, pix_out_nxt;

  // lead code 1 maps to 2 clocks; a single clock of lead is not offered
  function automatic logic [4:0] lead_cycles(input logic [2:0] code);
    if (code == 3'h0) begin
      lead_cycles = 5'h00;
    end else begin
      lead_cycles = {2'b00, code} + 5'h01;
    end
  endfunction : lead_cycles

  function automatic logic is_stn(input logic [3:0] ptype);
    is_stn = (ptype == plss_pkg::PTYPE_DSTN24) ||
             (ptype == plss_pkg::PTYPE_DSTN16) ||
             (ptype == plss_pkg::PTYPE_SSTN8);
  endfunction : is_stn

  // ---------------- register views
  always_comb begin
    ctrl_a_view = 32'h0000_0000;
    ctrl_a_view[plss_pkg::A_IN_POL_BIT] = in_pol_r;
    ctrl_a_view[plss_pkg::A_REGEN_BIT] = regen_r;
    ctrl_a_view[plss_pkg::A_LINES_LSB +: LW] = lines_r;
    ctrl_a_view[plss_pkg::A_LEAD_LSB +: plss_pkg::A_LEAD_W] = lead_code_r;
    ctrl_a_view[plss_pkg::A_TRAIL_LSB +: plss_pkg::A_TRAIL_W] = trail_code_r;
    ctrl_b_view = 32'h0000_0000;
    ctrl_b_view[plss_pkg::B_BYPASS_BIT] = bypass_r;
    ctrl_b_view[plss_pkg::B_HS_OUT_SEL_BIT] = hs_out_sel_r;
    ctrl_b_view[plss_pkg::B_VS_POL_EN_BIT] = vs_pol_en_r;
    ctrl_b_view[plss_pkg::B_VS_POL_BIT] = vs_pol_r;
    ctrl_b_view[plss_pkg::B_HS_POL_BIT] = hs_pol_r;
    ctrl_b_view[plss_pkg::B_PTYPE_LSB +: plss_pkg::B_PTYPE_W] = ptype_r;
    status_view = 32'h0000_0000;
    status_view[plss_pkg::S_LINE_LSB +: LW] = line_idx;
    status_view[plss_pkg::S_MARK_BIT] = marker;
    status_view[plss_pkg::S_PULSE_BIT] = shaped_pulse;
    status_view[plss_pkg::S_BYPASS_BIT] = bypass_r;
  end

  // ---------------- register writes and reads
  always_comb begin
    in_pol_nxt = in_pol_r;
    regen_nxt = regen_r;
    lines_nxt = lines_r;
    lead_code_nxt = lead_code_r;
    trail_code_nxt = trail_code_r;
    bypass_nxt = bypass_r;
    hs_out_sel_nxt = hs_out_sel_r;
    vs_pol_en_nxt = vs_pol_en_r;
    vs_pol_nxt = vs_pol_r;
    hs_pol_nxt = hs_pol_r;
    ptype_nxt = ptype_r;
    if (reg_wr && (reg_addr == plss_pkg::OFS_CTRL_A)) begin
      in_pol_nxt = reg_wdata[plss_pkg::A_IN_POL_BIT];
      regen_nxt = reg_wdata[plss_pkg::A_REGEN_BIT];
      lines_nxt = reg_wdata[plss_pkg::A_LINES_LSB +: LW];
      lead_code_nxt = reg_wdata[plss_pkg::A_LEAD_LSB +: plss_pkg::A_LEAD_W];
      trail_code_nxt =
        reg_wdata[plss_pkg::A_TRAIL_LSB +: plss_pkg::A_TRAIL_W];
    end
    if (reg_wr && (reg_addr == plss_pkg::OFS_CTRL_B)) begin
      bypass_nxt = reg_wdata[plss_pkg::B_BYPASS_BIT];
      hs_out_sel_nxt = reg_wdata[plss_pkg::B_HS_OUT_SEL_BIT];
      vs_pol_en_nxt = reg_wdata[plss_pkg::B_VS_POL_EN_BIT];
      vs_pol_nxt = reg_wdata[plss_pkg::B_VS_POL_BIT];
      hs_pol_nxt = reg_wdata[plss_pkg::B_HS_POL_BIT];
      ptype_nxt = reg_wdata[plss_pkg::B_PTYPE_LSB +: plss_pkg::B_PTYPE_W];
    end
    // read data only stand in the cycle after the strobe
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        plss_pkg::OFS_CTRL_A: rdata_nxt = ctrl_a_view;
        plss_pkg::OFS_CTRL_B: rdata_nxt = ctrl_b_view;
        plss_pkg::OFS_STATUS: rdata_nxt = status_view;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_pol_r <= plss_pkg::CTRL_A_RESET[plss_pkg::A_IN_POL_BIT];
      regen_r <= plss_pkg::CTRL_A_RESET[plss_pkg::A_REGEN_BIT];
      lines_r <= plss_pkg::CTRL_A_RESET[plss_pkg::A_LINES_LSB +: LW];
      lead_code_r <=
        plss_pkg::CTRL_A_RESET[plss_pkg::A_LEAD_LSB +: plss_pkg::A_LEAD_W];
      trail_code_r <=
        plss_pkg::CTRL_A_RESET[plss_pkg::A_TRAIL_LSB +: plss_pkg::A_TRAIL_W];
      bypass_r <= plss_pkg::CTRL_B_RESET[plss_pkg::B_BYPASS_BIT];
      hs_out_sel_r <= plss_pkg::CTRL_B_RESET[plss_pkg::B_HS_OUT_SEL_BIT];
      vs_pol_en_r <= plss_pkg::CTRL_B_RESET[plss_pkg::B_VS_POL_EN_BIT];
      vs_pol_r <= plss_pkg::CTRL_B_RESET[plss_pkg::B_VS_POL_BIT];
      hs_pol_r <= plss_pkg::CTRL_B_RESET[plss_pkg::B_HS_POL_BIT];
      ptype_r <=
        plss_pkg::CTRL_B_RESET[plss_pkg::B_PTYPE_LSB +: plss_pkg::B_PTYPE_W];
      rdata_r <= 32'h0000_0000;
    end else begin
      in_pol_r <= in_pol_nxt;
      regen_r <= regen_nxt;
      lines_r <= lines_nxt;
      lead_code_r <= lead_code_nxt;
      trail_code_r <= trail_code_nxt;
      bypass_r <= bypass_nxt;
      hs_out_sel_r <= hs_out_sel_nxt;
      vs_pol_en_r <= vs_pol_en_nxt;
      vs_pol_r <= vs_pol_nxt;
      hs_pol_r <= hs_pol_nxt;
      ptype_r <= ptype_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ---------------- input sync normalising and edge detection
  always_comb begin
    line_norm = incoming_line_sync ^ in_pol_r;
    line_edge = line_norm && !line_prev_r;
    frame_norm = incoming_frame_sync;
    frame_edge = frame_norm && !frame_prev_r;
    // without regen the normalised sync reaches the pins two clocks late
    line_pass_nxt = line_norm;
    lead_cyc = lead_cycles(lead_code_r);
    trail_cyc = trail_code_r;
    dual_scan = (ptype_r == plss_pkg::PTYPE_DSTN24) ||
                (ptype_r == plss_pkg::PTYPE_DSTN16);
    single_scan = is_stn(ptype_r) && !dual_scan;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_prev_r <= 1'b0;
      frame_prev_r <= 1'b0;
      line_pass_r <= 1'b0;
    end else begin
      line_prev_r <= line_norm;
      frame_prev_r <= frame_norm;
      line_pass_r <= line_pass_nxt;
    end
  end

  plss_edge_pulse #(
    .CNT_W(5)
  ) u_edge_pulse (
    .clock(clock),
    .rst_n(rst_n),
    .start(line_edge),
    .lead(lead_cyc),
    .trail(trail_cyc),
    .pulse_r(shaped_pulse)
  );

  plss_frame_marker #(
    .LINE_W(LW)
  ) u_frame_marker (
    .clock(clock),
    .rst_n(rst_n),
    .line_edge(line_edge),
    .frame_edge(frame_edge),
    .frame_level(frame_norm),
    .dual_scan(dual_scan),
    .single_scan(single_scan),
    .line_count(lines_r),
    .marker_r(marker),
    .line_idx_r(line_idx)
  );

  // ---------------- panel pin drive
  always_comb begin
    if (bypass_r) begin
      // raw inputs reach the pins through the output flops one clock late, shaping unused
      line_out_nxt = incoming_line_sync;
      mark_out_nxt = incoming_frame_sync;
      pix_out_nxt = incoming_pixel_data;
    end else begin
      if (regen_r) begin
        line_out_nxt = shaped_pulse;
      end else begin
        line_out_nxt = line_pass_r;
      end
      // output polarity is independent of the input polarity bit
      if (hs_out_sel_r) begin
        line_out_nxt = line_out_nxt ^ hs_pol_r;
      end
      mark_out_nxt = marker;
      if (vs_pol_en_r) begin
        mark_out_nxt = marker ^ vs_pol_r;
      end
      pix_out_nxt = internal_pixel_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_out_r <= 1'b0;
      mark_out_r <= 1'b0;
      pix_out_r <= '0;
    end else begin
      line_out_r <= line_out_nxt;
      mark_out_r <= mark_out_nxt;
      pix_out_r <= pix_out_nxt;
    end
  end

  assign panel_line_pulse = line_out_r;
  assign frame_start_marker = mark_out_r;
  assign panel_pixel_data = pix_out_r;
endmodule : plss_line_sync_shaper

// File: verilog/plss_pkg.sv
// constants for the panel line-sync shaper: register map, fields, resets
// assumes a single pixel clock domain and a word-wide register port
// Overview of operation
// - timing register A resets to all zeros
// - bit 29 selects incoming line sync polarity
// - output line sync polarity set in register B
// - line count field holds panel height
// - line count used only in STN modes
// - delays measured from normalised sync asserting edge
// - lead code 0 none, 1..7 give 2..8
// - trail not after lead gives no pulse
// - trail code 1..31 clocks, zero no pulse
// - dual scan marker at line one and half
// - bypass drives panel pins from inputs, registered one clock late
package plss_pkg;
  localparam logic [11:0] OFS_CTRL_A = 12'h400;
  localparam logic [11:0] OFS_CTRL_B = 12'h404;
  localparam logic [11:0] OFS_STATUS = 12'h408;
  localparam logic [31:0] CTRL_A_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_B_RESET = 32'h0000_0000;
  // register A fields
  localparam int A_IN_POL_BIT = 29;
  localparam int A_REGEN_BIT = 27;
  localparam int A_LINES_LSB = 16;
  localparam int A_LINES_W = 11;
  localparam int A_LEAD_LSB = 5;
  localparam int A_LEAD_W = 3;
  localparam int A_TRAIL_LSB = 0;
  localparam int A_TRAIL_W = 5;
  // register B fields
  localparam int B_BYPASS_BIT = 30;
  localparam int B_HS_OUT_SEL_BIT = 26;
  localparam int B_VS_POL_EN_BIT = 24;
  localparam int B_VS_POL_BIT = 23;
  localparam int B_HS_POL_BIT = 22;
  localparam int B_PTYPE_LSB = 18;
  localparam int B_PTYPE_W = 4;
  // panel type codes; all other codes are TFT
  localparam logic [3:0] PTYPE_DSTN24 = 4'h0;
  localparam logic [3:0] PTYPE_DSTN16 = 4'h1;
  localparam logic [3:0] PTYPE_SSTN8 = 4'h2;
  // status register fields
  localparam int S_LINE_LSB = 0;
  localparam int S_MARK_BIT = 16;
  localparam int S_PULSE_BIT = 17;
  localparam int S_BYPASS_BIT = 18;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  typedef enum logic [2:0] {
    PLSS_WAIT_FRAME = 3'b001,
    PLSS_FIRST_LINE = 3'b010,
    PLSS_COUNT = 3'b100
  } plss_frame_st_t;
endpackage : plss_pkg
